// [bench/line_src.sv]
// Line unit and telecom bus source model for one channel
`timescale 1ns/1ps
module line_src
  import pin_mux_pkg::*;
(
  input wire logic bus_en,
  input wire logic odd,
  input wire logic wide,
  input wire logic bad,
  input wire logic run,
  input wire logic [7:0] pat,
  output tbus_t bus,
  output logic lclk
);
  logic [1:0] st = 2'h0;
  logic [7:0] sh = 8'h96;
  logic p = 1'b0;
  initial lclk = 1'b0;
  ////////////////////////////////////////
  // Clock still outside frames; idle pin toggles so stale data never matches
  // Offset 2 ns so pin and line clock never move on a clk edge
  initial
  begin
    #2;
    forever
    begin
      #20;
      st = st + 2'h1;
      if (bus_en)
        lclk = 1'b0;
      else if (!st[0])
        lclk = (run || lclk) ? ~lclk : lclk;
      else if (lclk)
      begin
        sh = {sh[6:0], sh[7]};
        p = sh[7];
      end
      else if (!run)
        p = ~p;
    end
  end
  assign bus.data = pat;
  assign bus.payload = pat[0];
  assign bus.marker = pat[1];
  assign bus.parity = bus_en ? (^pat ^ (wide & (pat[0] ^ pat[1])) ^ odd ^ bad) : p;
endmodule

// [bench/tributary_input_pin_mux_tb.sv]
// Self-checking bench for the tributary input pin mux
`timescale 1ns/1ps
module tributary_input_pin_mux_tb;
  import pin_mux_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [WB_AW-1:0] adr = '0;
  logic [WB_DW-1:0] wdat = '0;
  logic [WB_DW-1:0] rdat;
  logic [WB_DW-1:0] t;
  logic ack, irq, lk1, lk2, bit1, bit2, sb1, sb2;
  logic [1:0] ben = 2'h0;
  logic [1:0] bad = 2'h0;
  logic odd = 1'b0;
  logic wide = 1'b0;
  logic run = 1'b0;
  logic [7:0] pat = 8'h5d;
  tbus_t b1, b2;
  int n_fail, checks, ne1, ne2, ns1, ns2;
  logic q1[$];
  logic q2[$];
  always #4 clk = ~clk;
  line_src m1 (.bus_en(ben[0]), .odd(odd), .wide(wide), .bad(bad[0]), .run(run),
    .pat(pat), .bus(b1), .lclk(lk1));
  line_src m2 (.bus_en(ben[1]), .odd(odd), .wide(wide), .bad(bad[1]), .run(run),
    .pat(pat), .bus(b2), .lclk(lk2));
  tributary_input_pin_mux dut (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .tx_bus_parity_in_ch1(b1.parity),
    .tx_bus_data_ch1(b1.data), .tx_payload_flag_ch1(b1.payload),
    .tx_frame_marker_ch1(b1.marker), .rx_line_clock_ch1(lk1),
    .tx_bus_parity_in_ch2(b2.parity), .tx_bus_data_ch2(b2.data),
    .tx_payload_flag_ch2(b2.payload), .tx_frame_marker_ch2(b2.marker),
    .rx_line_clock_ch2(lk2), .rx_line_bit_ch1(bit1), .rx_line_strobe_ch1(sb1),
    .rx_line_bit_ch2(bit2), .rx_line_strobe_ch2(sb2), .irq(irq));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Ack and read data taken at the rising edge; release follows by NBA there
  task automatic wb(input logic w, input logic [9:0] ix, input logic [7:0] d,
    input logic [3:0] s);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    wdat <= {24'h00_0000, d};
    sel <= s;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1)
    begin
      n_fail++;
      final_report();
    end
    t = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] ix, input logic [7:0] e, input string nm);
    wb(1'b0, ix, 8'h00, 4'hf);
    chk(nm, {24'h00_0000, e}, t);
  endtask
  ////////////////////////////////////////
  always @(posedge lk1)
    q1.push_back(b1.parity);
  always @(negedge lk2)
    q2.push_back(b2.parity);
  always @(negedge clk)
  begin
    if (sb1 === 1'b1)
    begin
      ns1++;
      if (q1.size() > 0)
        chk("line bit 1", q1.pop_front(), bit1);
      else
        chk("line extra strobe 1", 1, 0);
    end
    if (sb2 === 1'b1)
    begin
      ns2++;
      if (q2.size() > 0)
        chk("line bit 2", q2.pop_front(), bit2);
      else
        chk("line extra strobe 2", 1, 0);
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(IDX_CTRL_CH1, 8'h00, "ctrl1");
    rd(IDX_CTRL_CH2, 8'h00, "ctrl2");
    rd(IDX_MODE, 8'h00, "mode");
    rd(IDX_STATUS, 8'h00, "status");
    rd(IDX_MASK, 8'h00, "mask");
    rd(IDX_ERRCNT_CH1, 8'h00, "errcnt1");
    rd(10'h3ff, 8'h00, "unmapped");
    wb(1'b1, IDX_CTRL_CH1, 8'h03, 4'hf);
    wb(1'b1, IDX_CTRL_CH2, 8'h01, 4'hf);
    wb(1'b1, IDX_CTRL_CH2, 8'h02, 4'he);
    rd(IDX_CTRL_CH1, 8'h03, "ctrl1 rw");
    rd(IDX_CTRL_CH2, 8'h01, "ctrl2 rw");
    // Clock enable low must hold off the answer and the write
    ce <= 1'b0;
    fork
      wb(1'b1, IDX_MASK, 8'h02, 4'hf);
      begin
        repeat (6) @(posedge clk);
        chk("ce hold ack", 0, ack);
        ce <= 1'b1;
      end
    join
    rd(IDX_MASK, 8'h02, "ce freeze");
    $display("test registers done");
    wb(1'b1, IDX_MODE, 8'h08, 4'hf);
    q1.delete();
    q2.delete();
    ns1 = 0;
    ns2 = 0;
    run <= 1'b1;
    repeat (400) @(posedge clk);
    run <= 1'b0;
    repeat (40) @(posedge clk);
    ne1 = ns1 + q1.size();
    ne2 = ns2 + q2.size();
    chk("strobes 1", ne1, ns1);
    chk("strobes 2", ne2, ns2);
    chk("frame", 1, ns1 > 30 && ns2 > 30);
    $display("test line data done");
    ns1 = 0;
    ns2 = 0;
    wb(1'b1, IDX_MODE, 8'h03, 4'hf);
    ben <= 2'h3;
    wb(1'b1, IDX_MASK, 8'h03, 4'hf);
    for (int c = 0; c < 4; c++)
    begin
      odd <= c[0];
      wide <= c[1];
      pat <= pat + 8'h3c;
      wb(1'b1, IDX_CTRL_CH1, 8'(c), 4'hf);
      wb(1'b1, IDX_CTRL_CH2, 8'(c), 4'hf);
      repeat (10) @(posedge clk);
      wb(1'b1, IDX_STATUS, 8'h03, 4'hf);
      repeat (10) @(posedge clk);
      rd(IDX_STATUS, 8'h00, "good parity");
      bad <= 2'h1;
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk("irq", 1, irq);
      @(posedge clk);
      bad <= 2'h2;
      repeat (10) @(posedge clk);
      rd(IDX_STATUS, 8'h03, "bad parity");
      bad <= 2'h0;
      wb(1'b1, IDX_STATUS, 8'h01, 4'hf);
      rd(IDX_STATUS, 8'h02, "w1c");
    end
    wb(1'b1, IDX_MASK, 8'h00, 4'hf);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("irq masked", 0, irq);
    chk("bus strobes", 0, ns1 + ns2);
    chk("bus bit", 0, bit1);
    chk("bus bit 2", 0, bit2);
    wb(1'b0, IDX_ERRCNT_CH1, 8'h00, 4'hf);
    chk("errcnt1 counts", 1, t[7:0] != 8'h00);
    wb(1'b1, IDX_ERRCNT_CH2, 8'h00, 4'hf);
    rd(IDX_ERRCNT_CH2, 8'h00, "errcnt2 clear");
    $display("test bus parity done");
    final_report();
  end
endmodule

// [core/chan_pin.sv]
// One channel: parity check or line data sampling on the shared pin
`timescale 1ns/1ps
module chan_pin
  import pin_mux_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire chan_cfg_t cfg,
  input wire tbus_t bus,
  input wire logic lclk,
  output chan_out_t out
);

  typedef struct packed {
    tbus_t bus_s1;
    tbus_t bus_s2;
    tbus_t bus_d;
    logic clk_s1;
    logic clk_s2;
    logic clk_d;
    chan_out_t out;
  } chan_st_t;

  chan_st_t st_r;
  chan_st_t st_nxt;
  logic rise;
  logic fall;
  logic take;
  logic stable;
  logic expect_par;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    // Pins pass two flops before any logic looks at them
    st_nxt.bus_s1 = bus;
    st_nxt.bus_s2 = st_r.bus_s1;
    st_nxt.bus_d = st_r.bus_s2;
    st_nxt.clk_s1 = lclk;
    st_nxt.clk_s2 = st_r.clk_s1;
    st_nxt.clk_d = st_r.clk_s2;
    rise = st_r.clk_s2 & ~st_r.clk_d;
    fall = ~st_r.clk_s2 & st_r.clk_d;
    take = cfg.fall ? fall : rise;
    // Bus has no byte strobe here: check only once it held still a cycle
    stable = (st_r.bus_s2 == st_r.bus_d);
    expect_par = ^st_r.bus_s2.data ^ cfg.odd;
    if (cfg.wide)
    begin
      expect_par = expect_par ^ st_r.bus_s2.payload ^ st_r.bus_s2.marker;
    end
    if (cfg.bus_en)
    begin
      // Pin is the bus parity input, line path silent
      st_nxt.out.strobe = 1'b0;
      st_nxt.out.bit_val = 1'b0;
      st_nxt.out.perr = stable & (st_r.bus_s2.parity != expect_par);
    end
    else
    begin
      st_nxt.out.perr = 1'b0;
      st_nxt.out.strobe = take;
      if (take)
      begin
        st_nxt.out.bit_val = st_r.bus_s2.parity;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign out = st_r.out;

  ////////////////////////////////////////////////////////////////////////////
  chk_bus_mute: assert property (
    @(posedge clk) disable iff (rst)
    ce && cfg.bus_en |=> !out.strobe && !out.bit_val)
    else $error("line strobe while bus enabled");

  chk_no_err_off: assert property (
    @(posedge clk) disable iff (rst)
    ce && !cfg.bus_en |=> !out.perr)
    else $error("parity error while bus disabled");

  chk_edge_sample: assert property (
    @(posedge clk) disable iff (rst)
    ce && !cfg.bus_en && (cfg.fall ? fall : rise)
    |=> out.strobe && (out.bit_val == $past(st_r.bus_s2.parity)))
    else $error("selected line edge not sampled");

  chk_parity_flag: assert property (
    @(posedge clk) disable iff (rst)
    ce && cfg.bus_en && !cfg.wide && stable
    && ((^{st_r.bus_s2.data, st_r.bus_s2.parity}) != cfg.odd)
    |=> out.perr)
    else $error("data parity mismatch not flagged");

  chk_wide_flag: assert property (
    @(posedge clk) disable iff (rst)
    ce && cfg.bus_en && cfg.wide && stable
    && ((^st_r.bus_s2) != cfg.odd)
    |=> out.perr)
    else $error("wide parity mismatch not flagged");

endmodule

// [core/tributary_input_pin_mux.sv]
// Two-channel dual-function input pin mux with Wishbone registers
`timescale 1ns/1ps
// Function
// - Each channel pin goes to bus parity or line data per bus enable.
// - Bus enabled: pin carries even or odd parity of eight data bits.
// - Optional coverage adds payload flag and frame marker to the parity.
// - Parity sense and coverage set in per-channel control registers.
// - Bus disabled: pin sampled on chosen line clock edge for framer.
module tributary_input_pin_mux
  import pin_mux_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DW-1:0] wb_dat_i,
  output logic [WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tx_bus_parity_in_ch1,
  input wire logic [7:0] tx_bus_data_ch1,
  input wire logic tx_payload_flag_ch1,
  input wire logic tx_frame_marker_ch1,
  input wire logic rx_line_clock_ch1,
  input wire logic tx_bus_parity_in_ch2,
  input wire logic [7:0] tx_bus_data_ch2,
  input wire logic tx_payload_flag_ch2,
  input wire logic tx_frame_marker_ch2,
  input wire logic rx_line_clock_ch2,
  output logic rx_line_bit_ch1,
  output logic rx_line_strobe_ch1,
  output logic rx_line_bit_ch2,
  output logic rx_line_strobe_ch2,
  output logic irq
);

  typedef struct packed {
    logic ack;
    logic [WB_DW-1:0] rdat;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [3:0] mode;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [7:0] errcnt1;
    logic [7:0] errcnt2;
    logic irq;
  } top_st_t;

  top_st_t st_r;
  top_st_t st_nxt;
  tbus_t bus1;
  tbus_t bus2;
  chan_cfg_t cfg1;
  chan_cfg_t cfg2;
  chan_out_t out1;
  chan_out_t out2;
  logic hit;
  logic wr;
  logic [9:0] idx;
  logic [1:0] ev;
  logic [1:0] clr;
  logic [WB_DW-1:0] rd;

  ////////////////////////////////////////////////////////////////////////////
  // Pin bundles per channel; the shared pin rides in the parity field
  assign bus1 = '{data: tx_bus_data_ch1, payload: tx_payload_flag_ch1,
                  marker: tx_frame_marker_ch1, parity: tx_bus_parity_in_ch1};
  assign bus2 = '{data: tx_bus_data_ch2, payload: tx_payload_flag_ch2,
                  marker: tx_frame_marker_ch2, parity: tx_bus_parity_in_ch2};

  assign cfg1 = '{odd: st_r.ctrl1[CTRL_ODD_BIT],
                  wide: st_r.ctrl1[CTRL_WIDE_BIT],
                  bus_en: st_r.mode[MODE_EN_CH1_BIT],
                  fall: st_r.mode[MODE_FALL_CH1_BIT]};
  assign cfg2 = '{odd: st_r.ctrl2[CTRL_ODD_BIT],
                  wide: st_r.ctrl2[CTRL_WIDE_BIT],
                  bus_en: st_r.mode[MODE_EN_CH2_BIT],
                  fall: st_r.mode[MODE_FALL_CH2_BIT]};

  ////////////////////////////////////////////////////////////////////////////
  chan_pin u_ch1 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .cfg(cfg1),
    .bus(bus1),
    .lclk(rx_line_clock_ch1),
    .out(out1)
  );

  chan_pin u_ch2 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .cfg(cfg2),
    .bus(bus2),
    .lclk(rx_line_clock_ch2),
    .out(out2)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    // One access per request; ack drops the cycle after it rose
    hit = wb_cyc_i & wb_stb_i & ~st_r.ack;
    wr = hit & wb_we_i & wb_sel_i[0];
    idx = wb_adr_i[WB_AW-1:2];
    ev = {out2.perr, out1.perr};
    clr = 2'h0;
    rd = RD_ZERO;
    st_nxt.ack = hit;

    // Read decode; unmapped indices read zero and still ack
    if (idx == IDX_CTRL_CH1)
    begin
      rd = {24'h00_0000, st_r.ctrl1};
    end
    else if (idx == IDX_CTRL_CH2)
    begin
      rd = {24'h00_0000, st_r.ctrl2};
    end
    else if (idx == IDX_MODE)
    begin
      rd = {28'h000_0000, st_r.mode};
    end
    else if (idx == IDX_STATUS)
    begin
      rd = {30'h0000_0000, st_r.stat};
    end
    else if (idx == IDX_MASK)
    begin
      rd = {30'h0000_0000, st_r.mask};
    end
    else if (idx == IDX_ERRCNT_CH1)
    begin
      rd = {24'h00_0000, st_r.errcnt1};
    end
    else if (idx == IDX_ERRCNT_CH2)
    begin
      rd = {24'h00_0000, st_r.errcnt2};
    end
    if (hit)
    begin
      st_nxt.rdat = rd;
    end

    // Write decode; only byte lane 0 carries register bits
    if (wr)
    begin
      if (idx == IDX_CTRL_CH1)
      begin
        st_nxt.ctrl1 = wb_dat_i[7:0];
      end
      else if (idx == IDX_CTRL_CH2)
      begin
        st_nxt.ctrl2 = wb_dat_i[7:0];
      end
      else if (idx == IDX_MODE)
      begin
        st_nxt.mode = wb_dat_i[3:0];
      end
      else if (idx == IDX_STATUS)
      begin
        clr = wb_dat_i[1:0];
      end
      else if (idx == IDX_MASK)
      begin
        st_nxt.mask = wb_dat_i[1:0];
      end
      else if (idx == IDX_ERRCNT_CH1)
      begin
        st_nxt.errcnt1 = ERRCNT_RESET;
      end
      else if (idx == IDX_ERRCNT_CH2)
      begin
        st_nxt.errcnt2 = ERRCNT_RESET;
      end
    end

    // New event wins over a clear in the same cycle
    st_nxt.stat = (st_r.stat & ~clr) | ev;
    // Saturate rather than wrap so a flood stays visible
    if (ev[ST_PERR_CH1_BIT] && (st_nxt.errcnt1 != ERRCNT_MAX))
    begin
      st_nxt.errcnt1 = st_nxt.errcnt1 + 8'h01;
    end
    if (ev[ST_PERR_CH2_BIT] && (st_nxt.errcnt2 != ERRCNT_MAX))
    begin
      st_nxt.errcnt2 = st_nxt.errcnt2 + 8'h01;
    end
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r.ack <= 1'b0;
      st_r.rdat <= RD_ZERO;
      st_r.ctrl1 <= CTRL_RESET;
      st_r.ctrl2 <= CTRL_RESET;
      st_r.mode <= MODE_RESET;
      st_r.stat <= IRQ_RESET;
      st_r.mask <= IRQ_RESET;
      st_r.errcnt1 <= ERRCNT_RESET;
      st_r.errcnt2 <= ERRCNT_RESET;
      st_r.irq <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
  assign irq = st_r.irq;
  // Same sample feeds framer and overhead processor alike
  assign rx_line_bit_ch1 = out1.bit_val;
  assign rx_line_strobe_ch1 = out1.strobe;
  assign rx_line_bit_ch2 = out2.bit_val;
  assign rx_line_strobe_ch2 = out2.strobe;

  ////////////////////////////////////////////////////////////////////////////
  chk_ack_once: assert property (
    @(posedge clk) disable iff (rst)
    ce && wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  chk_ack_answer: assert property (
    @(posedge clk) disable iff (rst)
    ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");

  chk_ctrl_write: assert property (
    @(posedge clk) disable iff (rst)
    ce && wr && (idx == IDX_CTRL_CH1)
    |=> st_r.ctrl1 == $past(wb_dat_i[7:0]) && cfg1.odd == $past(wb_dat_i[0]))
     else $error("control write not applied");

  chk_sticky_set: assert property (
    @(posedge clk) disable iff (rst)
    ce && out1.perr |=> st_r.stat[ST_PERR_CH1_BIT])
    else $error("parity event lost");

  chk_sticky_keep: assert property (
    @(posedge clk) disable iff (rst)
    ce && st_r.stat[ST_PERR_CH2_BIT]
    && !(wr && (idx == IDX_STATUS) && wb_dat_i[ST_PERR_CH2_BIT])
    |=> st_r.stat[ST_PERR_CH2_BIT])
    else $error("sticky flag dropped without clear");

  chk_irq_level: assert property (
    @(posedge clk) disable iff (rst)
    ##1 irq == |(st_r.stat & st_r.mask))
    else $error("irq does not follow masked status");

endmodule

// [shared/pin_mux_pkg.sv]
// Types and constants shared by the tributary input pin mux
package pin_mux_pkg;

  localparam int unsigned WB_AW = 12;
  localparam int unsigned WB_DW = 32;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL_CH2 = 10'h139;
  localparam logic [9:0] IDX_CTRL_CH1 = 10'h13A;
  localparam logic [9:0] IDX_MODE = 10'h140;
  localparam logic [9:0] IDX_STATUS = 10'h141;
  localparam logic [9:0] IDX_MASK = 10'h142;
  localparam logic [9:0] IDX_ERRCNT_CH1 = 10'h143;
  localparam logic [9:0] IDX_ERRCNT_CH2 = 10'h144;

  // Interface control fields
  localparam int unsigned CTRL_ODD_BIT = 0;
  localparam int unsigned CTRL_WIDE_BIT = 1;

  // Mode register fields
  localparam int unsigned MODE_EN_CH1_BIT = 0;
  localparam int unsigned MODE_EN_CH2_BIT = 1;
  localparam int unsigned MODE_FALL_CH1_BIT = 2;
  localparam int unsigned MODE_FALL_CH2_BIT = 3;

  // Status and mask fields
  localparam int unsigned ST_PERR_CH1_BIT = 0;
  localparam int unsigned ST_PERR_CH2_BIT = 1;

  // Values after reset and the error count ceiling
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [7:0] ERRCNT_RESET = 8'h00;
  localparam logic [7:0] ERRCNT_MAX = 8'hFF;
  localparam logic [WB_DW-1:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] data;
    logic payload;
    logic marker;
    logic parity;
  } tbus_t;

  typedef struct packed {
    logic odd;
    logic wide;
    logic bus_en;
    logic fall;
  } chan_cfg_t;

  typedef struct packed {
    logic bit_val;
    logic strobe;
    logic perr;
  } chan_out_t;

endpackage
